/* File: rtl/dlb_core.sv */
// command-to-data latency and burst length logic with AHB-Lite registers
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dlb_params.svh"
module dlb_core
   import dlb_pkg::*;
(
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_hsel,
   input  wire logic [31:0]          i_haddr,
   input  wire logic [1:0]           i_htrans,
   input  wire logic                 i_hwrite,
   input  wire logic [2:0]           i_hsize,
   input  wire logic [31:0]          i_hwdata,
   input  wire logic                 i_hready,
   output logic                      o_hreadyout,
   output logic      [31:0]          o_hrdata,
   output logic                      o_hresp,
   input  wire logic                 i_cs_n,
   input  wire logic                 i_cmd_rd,
   input  wire logic                 i_cmd_wr,
   input  wire logic                 i_burst_select_address_bit,
   input  wire logic                 i_odt,
   input  wire logic                 i_dll_locked,
   input  wire logic [`DLB_DQ_W-1:0] i_dq,
   output logic                      o_on_die_termination,
   output logic      [`DLB_DQ_W-1:0] o_rd_data,
   output logic                      o_rd_valid,
   input  wire logic                 i_rd_ready
);
   dlb_state_type        s;
   dlb_state_type        n;
   logic                 mem_we;
   logic [2:0]           mem_wa;
   logic [`DLB_DQ_W-1:0] mem_wd;
   logic                 mem_re;
   logic [2:0]           mem_ra;
   logic [`DLB_DQ_W-1:0] mem_rd;
   logic                 cmd_ok;
   logic                 rd_cmd;
   logic                 wr_cmd;
   logic                 chop;
   logic                 pop;
   logic                 acc;
   logic [1:0]           idx;
   logic [2:0]           cal;
   logic [31:0]          cfg_view;

   dlb_mem #(
      .W     (`DLB_DQ_W),
      .DEPTH (8),
      .AW    (3)
   ) u_mem (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_we       (mem_we),
      .i_waddr    (mem_wa),
      .i_wdata    (mem_wd),
      .i_re       (mem_re),
      .i_raddr    (mem_ra),
      .o_rdata    (mem_rd)
   );

   always_comb begin
      n = s;
      mem_we = 1'b0;
      mem_wa = s.wr_ptr;
      mem_wd = s.s2[`DLB_S_DQ +: `DLB_DQ_W];
      mem_re = 1'b0;
      mem_ra = s.rd_ptr;
      // pins pass two flops; only the second stage is read
      n.s1 = {i_dq, i_dll_locked, i_odt, i_burst_select_address_bit,
              i_cmd_wr, i_cmd_rd, ~i_cs_n};
      n.s2 = s.s1;
      n.cs_hist = {s.cs_hist[6:0], s.s2[`DLB_S_CS]};
      n.on_die_termination = s.s2[`DLB_S_ODT];
      cal = s.cfg[`DLB_CAL_LSB +: `DLB_CAL_W];
      if (s.cfg[`DLB_CAL_EN_BIT] && (cal != 3'h0)) begin
         cmd_ok = s.cs_hist[cal - 3'h1];
      end else begin
         cmd_ok = s.s2[`DLB_S_CS];
      end
      rd_cmd = cmd_ok && s.s2[`DLB_S_RD];
      wr_cmd = cmd_ok && s.s2[`DLB_S_WR];
      chop = dlb_chop(s.cfg[`DLB_BL_LSB +: `DLB_BL_W], s.s2[`DLB_S_A12]);
      if ((rd_cmd && (s.rd_ph != DLB_IDLE))
          || (wr_cmd && (s.wr_ph != DLB_IDLE))) begin
         n.refuse_cnt = s.refuse_cnt + 8'h01;
      end

      pop = (s.fcnt != 2'h0) && i_rd_ready;
      n.rd_fly = 1'b0;
      if (s.rd_ph != DLB_IDLE) begin
         n.rd_age = s.rd_age + 7'h01;
      end
      case (s.rd_ph)
         DLB_IDLE: begin
            if (rd_cmd) begin
               n.rd_ph = DLB_WAIT;
               n.rd_lat = dlb_lat(s.cfg[`DLB_CL_LSB +: `DLB_CL_W],
                                  s.cfg[`DLB_AL_LSB +: `DLB_AL_W],
                                  s.cfg[`DLB_PE_BIT],
                                  s.cfg[`DLB_PL_LSB +: `DLB_PL_W]);
               n.rd_timer = n.rd_lat - 7'h01;
               n.rd_age = 7'h01;
               n.rd_chop = chop;
               n.last_chop = chop;
               n.rd_left = chop ? `DLB_BEATS4 : `DLB_BEATS8;
               n.rd_ptr = 3'h0;
            end
         end
         DLB_WAIT: begin
            n.rd_timer = s.rd_timer - 7'h01;
            // store read lands one cycle before the buffer
            if (s.rd_timer == 7'h03) begin
               n.rd_ph = DLB_BURST;
            end
         end
         DLB_BURST: begin
            // two slots: issue only if the word has room to land
            if ((s.fcnt - 2'(pop) + 2'(s.rd_fly)) < 2'h2) begin
               mem_re = 1'b1;
               n.rd_fly = 1'b1;
               n.rd_ptr = s.rd_ptr + 3'h1;
               n.rd_left = s.rd_left - 4'h1;
               if (s.rd_left == 4'h1) begin
                  n.rd_ph = DLB_IDLE;
               end
            end
         end
         default: n.rd_ph = DLB_IDLE;
      endcase

      if (pop) begin
         n.e0 = s.e1;
      end
      idx = s.fcnt - 2'(pop);
      if (s.rd_fly) begin
         if (idx == 2'h0) begin
            n.e0 = mem_rd;
         end else begin
            n.e1 = mem_rd;
         end
      end
      n.fcnt = idx + 2'(s.rd_fly);
      n.rvld = (n.fcnt != 2'h0);

      if (s.wr_ph != DLB_IDLE) begin
         n.wr_age = s.wr_age + 7'h01;
      end
      case (s.wr_ph)
         DLB_IDLE: begin
            if (wr_cmd) begin
               n.wr_ph = DLB_WAIT;
               n.wr_lat = dlb_lat(s.cfg[`DLB_CWL_LSB +: `DLB_CWL_W],
                                  s.cfg[`DLB_AL_LSB +: `DLB_AL_W],
                                  s.cfg[`DLB_PE_BIT],
                                  s.cfg[`DLB_PL_LSB +: `DLB_PL_W]);
               n.wr_timer = n.wr_lat - 7'h01;
               n.wr_age = 7'h01;
               n.wr_chop = chop;
               n.last_chop = chop;
               n.wr_left = chop ? `DLB_BEATS4 : `DLB_BEATS8;
               n.wr_ptr = 3'h0;
            end
         end
         DLB_WAIT: begin
            n.wr_timer = s.wr_timer - 7'h01;
            if (s.wr_timer == 7'h01) begin
               n.wr_ph = DLB_BURST;
            end
         end
         DLB_BURST: begin
            if (s.s2[`DLB_S_DLL]) begin
               mem_we = 1'b1;
            end else begin
               n.drop_cnt = s.drop_cnt + 8'h01;
            end
            n.wr_ptr = s.wr_ptr + 3'h1;
            n.wr_left = s.wr_left - 4'h1;
            if (s.wr_left == 4'h1) begin
               n.wr_ph = DLB_IDLE;
            end
         end
         default: n.wr_ph = DLB_IDLE;
      endcase

      // bus: write lands in data phase, read data set up in address phase
      acc = i_hsel && i_htrans[1] && i_hready;
      n.hready = 1'b1;
      n.ph_valid = acc && (i_hsize == `DLB_HSIZE_WORD);
      n.ph_write = i_hwrite;
      n.ph_addr = i_haddr[7:0];
      cfg_view = s.cfg;
      if (s.ph_valid && s.ph_write && (s.ph_addr == `DLB_CFG_OFFSET)) begin
         n.cfg = i_hwdata;
         cfg_view = i_hwdata;
      end
      if (acc && !i_hwrite) begin
         if (i_haddr[7:0] == `DLB_CFG_OFFSET) begin
            n.hrdata = cfg_view;
         end else if (i_haddr[7:0] == `DLB_STAT_OFFSET) begin
            n.hrdata = {8'h00, s.refuse_cnt, s.drop_cnt, 4'h0, s.last_chop,
                        s.s2[`DLB_S_DLL], s.wr_ph != DLB_IDLE,
                        s.rd_ph != DLB_IDLE};
         end else begin
            n.hrdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         s <= '0;
         s.cfg <= `DLB_CFG_RESET;
         s.rd_ph <= DLB_IDLE;
         s.wr_ph <= DLB_IDLE;
         s.hready <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign o_hreadyout = s.hready;
   assign o_hrdata = s.hrdata;
   assign o_hresp = 1'b0;
   assign o_on_die_termination = s.on_die_termination;
   assign o_rd_data = s.e0;
   assign o_rd_valid = s.rvld;

   property p_rd_lat;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s.rd_ph == DLB_BURST) && ($past(s.rd_ph) == DLB_WAIT)
         |-> (s.rd_age == s.rd_lat - 7'h02);
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read burst start off its latency");

   property p_wr_lat;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s.wr_ph == DLB_BURST) && ($past(s.wr_ph) == DLB_WAIT)
         |-> (s.wr_age == s.wr_lat);
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write capture start off its latency");

   property p_bl8;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s.rd_ph == DLB_IDLE) && rd_cmd
         && (s.cfg[`DLB_BL_LSB +: `DLB_BL_W] == `DLB_BL_FIXED8)
         |=> (s.rd_left == 4'h8) ##1 (s.rd_ph == DLB_WAIT);
   endproperty
   a_bl8: assert property (p_bl8)
      else $error("fixed eight-beat burst not selected");

   property p_bc4_fixed;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s.wr_ph == DLB_IDLE) && wr_cmd
         && (s.cfg[`DLB_BL_LSB +: `DLB_BL_W] == `DLB_BL_CHOP4)
         |=> s.wr_chop && (s.wr_left == 4'h4);
   endproperty
   a_bc4_fixed: assert property (p_bc4_fixed)
      else $error("fixed chop not applied");

   property p_otf;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s.rd_ph == DLB_IDLE) && rd_cmd
         && (s.cfg[`DLB_BL_LSB +: `DLB_BL_W] == `DLB_BL_OTF)
         |=> (s.rd_chop == !$past(s.s2[`DLB_S_A12]));
   endproperty
   a_otf: assert property (p_otf)
      else $error("on-the-fly burst select wrong");

   property p_odt;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $changed(s.s2[`DLB_S_ODT])
         |=> (o_on_die_termination == $past(s.s2[`DLB_S_ODT]));
   endproperty
   a_odt: assert property (p_odt)
      else $error("termination delay changed");

   property p_dll;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      mem_we |-> s.s2[`DLB_S_DLL] && (s.wr_ph == DLB_BURST);
   endproperty
   a_dll: assert property (p_dll)
      else $error("write captured without locked loop");

   property p_cal;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s.cfg[`DLB_CAL_EN_BIT] && (cal == 3'h3) && rd_cmd
         |-> $past(s.s2[`DLB_S_CS], 3);
   endproperty
   a_cal: assert property (p_cal)
      else $error("command taken without earlier chip select");
endmodule

/* File: pkg/dlb_params.svh */
// offsets, field positions, reset values and codes of the latency/burst block
`ifndef DLB_PARAMS_SVH
`define DLB_PARAMS_SVH
`define DLB_CFG_OFFSET     8'h00
`define DLB_STAT_OFFSET    8'h04
`define DLB_CFG_RESET      32'h00C2600B
`define DLB_CL_LSB         0
`define DLB_CL_W           5
`define DLB_AL_LSB         5
`define DLB_AL_W           5
`define DLB_PE_BIT         10
`define DLB_PL_LSB         11
`define DLB_PL_W           3
`define DLB_CWL_LSB        14
`define DLB_CWL_W          5
`define DLB_BL_LSB         19
`define DLB_BL_W           2
`define DLB_CAL_EN_BIT     21
`define DLB_CAL_LSB        22
`define DLB_CAL_W          3
`define DLB_BL_FIXED8      2'h0
`define DLB_BL_OTF         2'h1
`define DLB_BL_CHOP4       2'h2
`define DLB_BEATS8         4'h8
`define DLB_BEATS4         4'h4
`define DLB_DQ_W           8
`define DLB_SYNC_W         14
`define DLB_S_CS           0
`define DLB_S_RD           1
`define DLB_S_WR           2
`define DLB_S_A12          3
`define DLB_S_ODT          4
`define DLB_S_DLL          5
`define DLB_S_DQ           6
`define DLB_HSIZE_WORD     3'h2
`endif

/* File: pkg/dlb_pkg.sv */
// types and shared decode functions of the latency/burst block
`include "dlb_params.svh"
package dlb_pkg;
   typedef enum logic [2:0] {
      DLB_IDLE  = 3'h1,
      DLB_WAIT  = 3'h2,
      DLB_BURST = 3'h4
   } dlb_phase_type;

   typedef struct packed {
      logic [`DLB_SYNC_W-1:0] s1;
      logic [`DLB_SYNC_W-1:0] s2;
      logic [7:0]             cs_hist;
      logic                   on_die_termination;
      logic [31:0]            cfg;
      dlb_phase_type          rd_ph;
      logic [6:0]             rd_timer;
      logic [3:0]             rd_left;
      logic [2:0]             rd_ptr;
      logic                   rd_fly;
      logic                   rd_chop;
      logic [6:0]             rd_age;
      logic [6:0]             rd_lat;
      logic [`DLB_DQ_W-1:0]   e0;
      logic [`DLB_DQ_W-1:0]   e1;
      logic [1:0]             fcnt;
      logic                   rvld;
      dlb_phase_type          wr_ph;
      logic [6:0]             wr_timer;
      logic [3:0]             wr_left;
      logic [2:0]             wr_ptr;
      logic                   wr_chop;
      logic [6:0]             wr_age;
      logic [6:0]             wr_lat;
      logic                   last_chop;
      logic [7:0]             drop_cnt;
      logic [7:0]             refuse_cnt;
      logic                   ph_valid;
      logic                   ph_write;
      logic [7:0]             ph_addr;
      logic [31:0]            hrdata;
      logic                   hready;
   } dlb_state_type;

   function automatic logic [6:0] dlb_lat(input logic [4:0] base,
                                          input logic [4:0] al,
                                          input logic       pe,
                                          input logic [2:0] pl);
      return 7'(base) + 7'(al) + (pe ? 7'(pl) : 7'h00);
   endfunction

   function automatic logic dlb_chop(input logic [1:0] mode,
                                     input logic       a12);
      return (mode == `DLB_BL_CHOP4) || ((mode == `DLB_BL_OTF) && !a12);
   endfunction
endpackage

/* File: rtl/dlb_mem.sv */
// burst data store with registered read port
`timescale 1ns/1ps
module dlb_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [W-1:0]  i_wdata,
   input  wire logic          i_re,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [W-1:0]  o_rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rdata;
   } dlb_mem_state_type;

   dlb_mem_state_type s;
   dlb_mem_state_type n;

   always_comb begin
      n = s;
      if (i_we) begin
         n.mem[i_waddr] = i_wdata;
      end
      // old word on a same-address collision
      if (i_re) begin
         n.rdata = s.mem[i_raddr];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_rdata = s.rdata;
endmodule

/* File: verif/dlb_ctrl_model.sv */
// behavioural memory controller driving command and write data pins
`timescale 1ns/1ps
`include "dlb_params.svh"
module dlb_ctrl_model (
   input  wire logic                 i_core_clk,
   output logic                      o_cs_n,
   output logic                      o_cmd_rd,
   output logic                      o_cmd_wr,
   output logic                      o_burst_select_address_bit,
   output logic      [`DLB_DQ_W-1:0] o_dq
);
   logic                 drv = 1'b0;
   logic [`DLB_DQ_W-1:0] beat = '0;
   initial begin
      o_cs_n = 1'b1;
      o_cmd_rd = 1'b0;
      o_cmd_wr = 1'b0;
      o_burst_select_address_bit = 1'b0;
      o_dq = '0;
   end
   // trained: beats land on capture edge
   // released data lines toggle so the first cycle after the last beat never matches it
   always @(posedge i_core_clk) begin
      o_dq <= drv ? beat : ~o_dq;
   end
   task automatic issue(input logic rd, input logic bsel, input int cal_cyc,
                        input int wr_lat, input int nb,
                        input logic [`DLB_DQ_W-1:0] d [8]);
      o_cs_n <= 1'b0;
      if (cal_cyc > 0) begin
         @(posedge i_core_clk);
         o_cs_n <= 1'b1;
         repeat (cal_cyc - 1) @(posedge i_core_clk);
      end
      o_cmd_rd <= rd;
      o_cmd_wr <= !rd;
      o_burst_select_address_bit <= bsel;
      @(posedge i_core_clk);
      o_cs_n <= 1'b1;
      o_cmd_rd <= 1'b0;
      o_cmd_wr <= 1'b0;
      if (!rd) begin
         repeat (wr_lat - 2) @(posedge i_core_clk);
         for (int i = 0; i < nb; i++) begin
            drv <= 1'b1;
            beat <= d[i];
            @(posedge i_core_clk);
         end
         drv <= 1'b0;
      end
   endtask
endmodule

/* File: verif/ddr4_read_write_latency_burst_bench.sv */
// self-checking bench for the latency and burst block
`timescale 1ns/1ps
`include "dlb_params.svh"
`define TB_CHK(g, e) begin checks++; if ((g) !== (e)) begin \
   mismatches++; $display("CHECK FAILED %0t got %0h want %0h", $time, \
   g, e); end end
module ddr4_read_write_latency_burst_bench;
   logic        clk = 1'b0;
   logic        rst_n, hsel, hwrite, hready, hresp, on_die_termination, dll, rd_ready;
   logic        o_odt, rd_valid, cs_n, cmd_rd, cmd_wr, bsel_pin, stall, run;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  rd_data, dq, ev;
   logic [7:0]  d [8];
   logic [7:0]  m [8];
   logic [7:0]  expq [$];
   logic [2:0]  oh = '0;
   int          checks = 0, mismatches = 0, cyc = 0, due = 0, rd_lat = 0;
   int          seed = 30, bfield, add_lat, par_en, cal_cyc, nb, w;
   bit          bsel, armed = 0;

   dlb_core i_dlb_core (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
      .i_cs_n(cs_n), .i_cmd_rd(cmd_rd), .i_cmd_wr(cmd_wr),
      .i_burst_select_address_bit(bsel_pin), .i_odt(on_die_termination),
      .i_dll_locked(dll), .i_dq(dq), .o_on_die_termination(o_odt),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready));
   dlb_ctrl_model i_dlb_ctrl_model (.i_core_clk(clk), .o_cs_n(cs_n),
      .o_cmd_rd(cmd_rd), .o_cmd_wr(cmd_wr),
      .o_burst_select_address_bit(bsel_pin), .o_dq(dq));

   always #2 clk = ~clk;

   always @(posedge clk) begin
      rd_ready <= stall ? 1'($random(seed)) : 1'b1;
      on_die_termination <= run ? 1'($random(seed)) : 1'b0;
   end

   // expected read beats, first-beat time and termination delay
   always @(posedge clk) begin
      cyc++;
      if (rst_n) begin
         `TB_CHK(o_odt, oh[2])
         if (cmd_rd && armed) begin
            due = cyc + rd_lat + 2;
            armed = 1'b0;
         end
         if (rd_valid && due != 0) begin
            `TB_CHK(cyc, due)
            due = 0;
         end
         if (rd_valid && rd_ready) begin
            ev = expq.size() ? expq.pop_front() : 8'hXX;
            `TB_CHK(rd_data, ev)
         end
      end
      oh = {oh[1:0], on_die_termination};
   end

   task automatic conclude();
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [2:0] sz,
                      input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, `DLB_HSIZE_WORD, a, 32'h0);
      `TB_CHK(r, e)
      `TB_CHK(hresp, 1'b0)
   endtask

   // a second read two cycles later must be refused
   task automatic rd_burst(input int n, input bit extra);
      for (int i = 0; i < n; i++) expq.push_back(m[i]);
      armed = 1'b1;
      i_dlb_ctrl_model.issue(1'b1, bsel, cal_cyc, 0, 0, d);
      if (extra) begin
         @(posedge clk);
         i_dlb_ctrl_model.issue(1'b1, bsel, cal_cyc, 0, 0, d);
      end
      w = 0;
      while (expq.size() > 0 && w < 300) begin
         @(posedge clk);
         w++;
      end
      `TB_CHK(expq.size(), 0)
   endtask

   task automatic burst(input int k);
      logic [31:0] cfg;
      bfield = k % 4;
      bsel = (k / 4) % 2;
      par_en = k % 2;
      cal_cyc = (k % 3 == 0) ? 0 : 2 + k % 3;
      add_lat = $random(seed) & 3;
      cfg = 32'(11 + (add_lat << `DLB_AL_LSB) + (par_en << `DLB_PE_BIT)
            + (4 << `DLB_PL_LSB) + (9 << `DLB_CWL_LSB)
            + (bfield << `DLB_BL_LSB) + (int'(cal_cyc > 0) << `DLB_CAL_EN_BIT)
            + (cal_cyc << `DLB_CAL_LSB));
      bus(1'b1, `DLB_HSIZE_WORD, `DLB_CFG_OFFSET, cfg);
      rd_lat = 11 + add_lat + 4 * par_en;
      nb = (bfield == 2 || (bfield == 1 && !bsel)) ? 4 : 8;
      for (int i = 0; i < 8; i++) d[i] = 8'($random(seed));
      for (int i = 0; i < nb; i++) m[i] = d[i];
      i_dlb_ctrl_model.issue(1'b0, bsel, cal_cyc, 9 + add_lat + 4 * par_en,
                             nb, d);
      stall <= k >= 8;
      rd_burst(nb, 1'b0);
      rd_chk(`DLB_STAT_OFFSET, {28'h0, nb == 4, 3'h4});
   endtask

   initial begin
      rst_n <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= `DLB_HSIZE_WORD;
      hwdata <= 32'h0;
      dll <= 1'b1;
      on_die_termination <= 1'b0;
      rd_ready <= 1'b1;
      stall <= 1'b0;
      run <= 1'b0;
      // sync stages are cleared by reset itself
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      run <= 1'b1;
      rd_chk(`DLB_CFG_OFFSET, `DLB_CFG_RESET);
      bus(1'b1, 3'h1, `DLB_CFG_OFFSET, 32'h0);
      rd_chk(`DLB_CFG_OFFSET, `DLB_CFG_RESET);
      bus(1'b1, `DLB_HSIZE_WORD, `DLB_STAT_OFFSET, 32'hFFFFFFFF);
      bus(1'b1, `DLB_HSIZE_WORD, 32'h10, 32'hFFFFFFFF);
      rd_chk(32'h10, 32'h0);
      rd_chk(`DLB_STAT_OFFSET, 32'h4);
      for (int k = 0; k < 12; k++) burst(k);
      bus(1'b1, `DLB_HSIZE_WORD, `DLB_CFG_OFFSET, `DLB_CFG_RESET);
      bsel = 1'b1;
      cal_cyc = 0;
      rd_lat = 11;
      stall <= 1'b0;
      dll <= 1'b0;
      for (int i = 0; i < 8; i++) d[i] = ~m[i];
      repeat (4) @(posedge clk);
      i_dlb_ctrl_model.issue(1'b0, 1'b1, 0, 9, 8, d);
      // lock only once the last beat has cleared the sync stages
      repeat (4) @(posedge clk);
      dll <= 1'b1;
      rd_burst(8, 1'b1);
      rd_chk(`DLB_STAT_OFFSET, 32'h00010804);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule
